// file: rtl/packet_buffer.sv
// holding register for one fetch packet, whole packet read from the register
`timescale 1ns/100ps
`include "packet_dispatch_defs.svh"
module packet_buffer (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic wr_en_i,
    input wire logic [`FETCH_BITS-1:0] wr_data_i,
    output logic [`FETCH_BITS-1:0] rd_data_o
);
    logic [`FETCH_BITS-1:0] store_r; // current fetch packet
    logic [`FETCH_BITS-1:0] store_nxt;
    ////////////////////////////////////////////////////////////////
    // next value: load on write, else hold
    always_comb begin
        store_nxt = store_r;
        if (wr_en_i) begin
            store_nxt = wr_data_i;
        end
    end
    // register
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            store_r <= '0;
        end else begin
            store_r <= store_nxt;
        end
    end
    assign rd_data_o = store_r;
endmodule

// file: rtl/packet_dispatch_defs.svh
// constants for the fetch and dispatch front end
`ifndef PACKET_DISPATCH_DEFS_SVH
`define PACKET_DISPATCH_DEFS_SVH
`define FETCH_BITS 256
`define SLOT_BITS 32
`define SLOT_COUNT 8
`define SLOT_IDX_BITS 3
`define LAST_SLOT 3'h7
`define CHAIN_BIT 0
`define REG_COUNT 16
`define REG_IDX_BITS 4
`define REG_BITS 32
`define ADDR_BITS 32
`define SLOT_A_LOGIC 0
`define SLOT_A_SHIFT 1
`define SLOT_A_MULT 2
`define SLOT_A_ADDR 3
`define SLOT_B_LOGIC 4
`define SLOT_B_SHIFT 5
`define SLOT_B_MULT 6
`define SLOT_B_ADDR 7
`endif

// file: rtl/packet_dispatch_pkg.sv
// types for the fetch and dispatch front end
package packet_dispatch_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_DISPATCH
    } fetch_state_type;
    typedef logic [255:0] fetch_word_type;
    typedef logic [31:0] instr_type;
    typedef logic [7:0] unit_mask_type;
endpackage

// file: rtl/vliw_packet_dispatch.sv
// fetch packet splitter and execute packet dispatcher
`timescale 1ns/100ps
`include "packet_dispatch_defs.svh"
module vliw_packet_dispatch (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    output logic fetch_req_o, // request next fetch packet
    input wire logic fetch_valid_i, // fetch packet present
    input wire packet_dispatch_pkg::fetch_word_type fetch_data_i,
    input wire logic [`SLOT_COUNT-1:0] unit_busy_i, // 1 = unit not ready
    output packet_dispatch_pkg::unit_mask_type issue_valid_o, // per unit issue strobe
    output packet_dispatch_pkg::fetch_word_type issue_instr_o, // instruction routed to unit i by its unit code
    output logic packet_issued_o, // one execute packet left this cycle
    output logic [`SLOT_IDX_BITS:0] packet_size_o, // instructions in that packet
    output logic cross_a_read_o, // side a reads side b file
    output logic cross_b_read_o, // side b reads side a file
    output logic cross_a_write_o, // side a writes side b file
    output logic cross_b_write_o // side b writes side a file
);
    import packet_dispatch_pkg::*;

    ////////////////////////////////////////////////////////////////
    // functions
    // slot i of a fetch packet
    function automatic instr_type slot_of(input fetch_word_type w, input logic [`SLOT_IDX_BITS-1:0] i);
        slot_of = w[i*`SLOT_BITS +: `SLOT_BITS];
    endfunction
    // unit code in an instruction: bits 3:1 name the unit (slot index)
    function automatic logic [`SLOT_IDX_BITS-1:0] unit_of(input instr_type ins);
        unit_of = ins[3:1];
    endfunction
    // cross-path flag in an instruction, bit 4
    function automatic logic cross_of(input instr_type ins);
        cross_of = ins[4];
    endfunction

    ////////////////////////////////////////////////////////////////
    // state
    fetch_state_type state_r, state_nxt; // fetch control
    logic [`SLOT_IDX_BITS-1:0] pos_r, pos_nxt; // first slot of next packet
    logic load_en; // capture fetch packet
    fetch_word_type pkt_data; // held fetch packet
    unit_mask_type mask; // slots in current execute packet
    logic [`SLOT_IDX_BITS-1:0] end_pos; // last slot of current packet
    logic stall; // busy bit set at the index of a slot in the packet
    unit_mask_type issue_valid_r, issue_valid_nxt;
    fetch_word_type issue_instr_r, issue_instr_nxt;
    logic issued_r, issued_nxt;
    logic [`SLOT_IDX_BITS:0] size_r, size_nxt;
    logic [3:0] cross_r, cross_nxt; // a_rd, b_rd, a_wr, b_wr
    logic fire; // packet leaves this cycle

    // buffer for the fetch packet
    packet_buffer u_buf (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .wr_en_i(load_en),
        .wr_data_i(fetch_data_i),
        .rd_data_o(pkt_data)
    );

    ////////////////////////////////////////////////////////////////
    // chain scan: walk from pos_r until a zero low bit or last slot
    always_comb begin
        mask = '0;
        end_pos = `LAST_SLOT;
        for (int k = 0; k < `SLOT_COUNT; k++) begin
            if (k >= pos_r && end_pos == `LAST_SLOT) begin
                mask[k] = 1'b1;
                if (!pkt_data[k*`SLOT_BITS + `CHAIN_BIT]) begin
                    end_pos = k[`SLOT_IDX_BITS-1:0];
                end
            end
        end
        // loop stops at slot seven, closing the packet there
    end

    // stall if the busy bit indexed by any slot in the packet is set
    always_comb begin
        stall = 1'b0;
        for (int k = 0; k < `SLOT_COUNT; k++) begin
            if (mask[k] && unit_busy_i[k]) begin
                stall = 1'b1;
            end
        end
    end

    // dispatch, capture and request strobes
    assign fire = (state_r == ST_DISPATCH) && !stall;
    assign load_en = (state_r == ST_WAIT) && fetch_valid_i;
    assign fetch_req_o = (state_r == ST_WAIT);

    ////////////////////////////////////////////////////////////////
    // fetch control next state
    always_comb begin
        state_nxt = state_r;
        pos_nxt = pos_r;
        case (state_r)
            ST_IDLE: begin
                state_nxt = ST_WAIT;
            end
            ST_WAIT: begin
                if (fetch_valid_i) begin
                    state_nxt = ST_DISPATCH;
                    pos_nxt = '0;
                end
            end
            ST_DISPATCH: begin
                if (fire) begin
                    if (end_pos == `LAST_SLOT) begin
                        state_nxt = ST_WAIT;
                        pos_nxt = '0;
                    end else begin
                        pos_nxt = end_pos + 3'h1;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // fetch control registers
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_r <= ST_IDLE;
            pos_r <= '0;
        end else begin
            state_r <= state_nxt;
            pos_r <= pos_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // issue: route each chained slot to its unit, others idle
    always_comb begin
        instr_type ins;
        logic [`SLOT_IDX_BITS-1:0] u;
        ins = '0;
        u = '0;
        issue_valid_nxt = '0;
        issue_instr_nxt = '0;
        issued_nxt = fire;
        size_nxt = '0;
        cross_nxt = '0;
        if (fire) begin
            for (int k = 0; k < `SLOT_COUNT; k++) begin
                ins = slot_of(pkt_data, k[`SLOT_IDX_BITS-1:0]);
                u = unit_of(ins);
                if (mask[k]) begin
                    size_nxt = size_nxt + 4'h1;
                    // slot routing by unit code keeps multiplies on multiply units
                    issue_valid_nxt[u] = 1'b1;
                    issue_instr_nxt[u*`SLOT_BITS +: `SLOT_BITS] = ins;
                    // one cross read flag per side, set if any slot of that side carries the cross bit
                    if (cross_of(ins) && u < 3'h4 && !cross_nxt[0]) begin
                        cross_nxt[0] = 1'b1;
                    end
                    if (cross_of(ins) && u >= 3'h4 && !cross_nxt[1]) begin
                        cross_nxt[1] = 1'b1;
                    end
                    // cross load/store target from address unit
                    if (cross_of(ins) && u == `SLOT_A_ADDR) begin
                        cross_nxt[2] = 1'b1;
                    end
                    if (cross_of(ins) && u == `SLOT_B_ADDR) begin
                        cross_nxt[3] = 1'b1;
                    end
                end
            end
        end
    end
    // condition, addressing mode, offset and width fields travel untouched in
    // the instruction word to the units

    // issue registers, idle and cleared in reset
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            issue_valid_r <= '0;
            issue_instr_r <= '0;
            issued_r <= 1'b0;
            size_r <= '0;
            cross_r <= '0;
        end else begin
            issue_valid_r <= issue_valid_nxt;
            issue_instr_r <= issue_instr_nxt;
            issued_r <= issued_nxt;
            size_r <= size_nxt;
            cross_r <= cross_nxt;
        end
    end

    // outputs come straight from the issue registers
    assign issue_valid_o = issue_valid_r;
    assign issue_instr_o = issue_instr_r;
    assign packet_issued_o = issued_r;
    assign packet_size_o = size_r;
    assign cross_a_read_o = cross_r[0];
    assign cross_b_read_o = cross_r[1];
    assign cross_a_write_o = cross_r[2];
    assign cross_b_write_o = cross_r[3];
endmodule

// file: verif/program_memory_model.sv
// program memory model offering whole fetch packets
`timescale 1ns/100ps
module program_memory_model (
    input wire logic clk_sys_i,
    input wire logic fetch_req_i,
    input wire packet_dispatch_pkg::fetch_word_type pkt_i,
    input wire logic [7:0] avail_i,
    output logic fetch_valid_o,
    output packet_dispatch_pkg::fetch_word_type fetch_data_o,
    output logic [7:0] sent_o
);
    import packet_dispatch_pkg::*;
    initial begin
        fetch_valid_o = 1'b0;
        fetch_data_o = '0;
        sent_o = 8'h00;
    end
    // count packets taken by the dispatcher
    always @(posedge clk_sys_i) begin
        if (fetch_req_i && fetch_valid_o) begin
            sent_o <= sent_o + 8'h01;
        end
    end
    // offer padded packets whole; released data toggles
    always @(negedge clk_sys_i) begin
        if (sent_o != avail_i) begin
            fetch_valid_o <= 1'b1;
            fetch_data_o <= pkt_i;
        end else begin
            fetch_valid_o <= 1'b0;
            fetch_data_o <= ~fetch_data_o;
        end
    end
endmodule

// file: verif/vliw_packet_dispatch_props.sv
// port checker for the execute packet dispatcher
`timescale 1ns/100ps
`include "packet_dispatch_defs.svh"
module vliw_packet_dispatch_props (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic fetch_req_o,
    input wire logic fetch_valid_i,
    input wire logic [`SLOT_COUNT-1:0] unit_busy_i,
    input wire packet_dispatch_pkg::unit_mask_type issue_valid_o,
    input wire packet_dispatch_pkg::fetch_word_type issue_instr_o,
    input wire logic packet_issued_o,
    input wire logic [`SLOT_IDX_BITS:0] packet_size_o,
    input wire logic cross_a_read_o,
    input wire logic cross_b_read_o,
    input wire logic cross_a_write_o,
    input wire logic cross_b_write_o
);
    import packet_dispatch_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////
    // packet shape and issue relations
    a_size_range: assert property (packet_issued_o |-> packet_size_o >= 4'h1 && packet_size_o <= 4'h8)
        else $error("packet size out of range");
    a_units_fit: assert property (packet_issued_o |-> $countones(issue_valid_o) <= packet_size_o)
        else $error("more units than packet size");
    a_strobe_owned: assert property (issue_valid_o != 8'h00 |-> packet_issued_o)
        else $error("unit strobe without packet");
    a_idle_quiet: assert property (!packet_issued_o |-> issue_instr_o == '0 && issue_valid_o == 8'h00)
        else $error("idle units not quiet");
    a_no_refetch: assert property (fetch_req_o && fetch_valid_i |=> !fetch_req_o)
        else $error("fetch request while dispatching");
    a_first_issue: assert property ((fetch_req_o && fetch_valid_i) ##1 (unit_busy_i == 8'h00)
        |=> packet_issued_o)
        else $error("first packet late");
    a_cross_a_rd: assert property (cross_a_read_o |-> issue_valid_o[3:0] != 4'h0)
        else $error("side a cross read without side a unit");
    a_cross_b_rd: assert property (cross_b_read_o |-> issue_valid_o[7:4] != 4'h0)
        else $error("side b cross read without side b unit");
    a_cross_wr: assert property ((cross_a_write_o |-> issue_valid_o[`SLOT_A_ADDR])
        and (cross_b_write_o |-> issue_valid_o[`SLOT_B_ADDR]))
        else $error("cross write without address unit");
endmodule
bind vliw_packet_dispatch vliw_packet_dispatch_props u_props (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .fetch_req_o(fetch_req_o), .fetch_valid_i(fetch_valid_i), .unit_busy_i(unit_busy_i),
    .issue_valid_o(issue_valid_o), .issue_instr_o(issue_instr_o), .packet_issued_o(packet_issued_o),
    .packet_size_o(packet_size_o), .cross_a_read_o(cross_a_read_o), .cross_b_read_o(cross_b_read_o),
    .cross_a_write_o(cross_a_write_o), .cross_b_write_o(cross_b_write_o));

// file: verif/vliw_packet_dispatch_test.sv
// testbench for the execute packet dispatcher
`timescale 1ns/100ps
module vliw_packet_dispatch_test;
    import packet_dispatch_pkg::*;
    logic clk_sys_i, srst_i, fetch_req_o, fetch_valid_i, packet_issued_o;
    logic cross_a_read_o, cross_b_read_o, cross_a_write_o, cross_b_write_o;
    logic [7:0] unit_busy_i, avail, sent;
    logic [3:0] packet_size_o;
    unit_mask_type issue_valid_o;
    fetch_word_type fetch_data_i, issue_instr_o, pkt;
    int fails, checked, cycles;
    vliw_packet_dispatch dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .fetch_req_o(fetch_req_o),
        .fetch_valid_i(fetch_valid_i), .fetch_data_i(fetch_data_i), .unit_busy_i(unit_busy_i),
        .issue_valid_o(issue_valid_o), .issue_instr_o(issue_instr_o), .packet_issued_o(packet_issued_o),
        .packet_size_o(packet_size_o), .cross_a_read_o(cross_a_read_o), .cross_b_read_o(cross_b_read_o),
        .cross_a_write_o(cross_a_write_o), .cross_b_write_o(cross_b_write_o));
    program_memory_model mem (.clk_sys_i(clk_sys_i), .fetch_req_i(fetch_req_o), .pkt_i(pkt),
        .avail_i(avail), .fetch_valid_o(fetch_valid_i), .fetch_data_o(fetch_data_i), .sent_o(sent));
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    ////////////////////////////////////////
    // one slot: marker, slot number, unit code equal to slot, chain bit
    function automatic fetch_word_type word(input logic [7:0] ch);
        fetch_word_type w;
        for (int k = 0; k < 8; k++) begin
            w[32*k +: 32] = {16'hC0DE, 8'(k), 3'h0, 1'b0, 3'(k), ch[k]};
        end
        return w;
    endfunction
    // same slots with the cross-path flag raised where cx is one
    function automatic fetch_word_type xword(input logic [7:0] ch, input logic [7:0] cx);
        fetch_word_type w;
        w = word(ch);
        for (int k = 0; k < 8; k++) begin
            w[32*k + 4] = cx[k];
        end
        return w;
    endfunction
    task automatic check(input logic [255:0] got, input logic [255:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t mismatch got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic offer(input fetch_word_type w);
        @(negedge clk_sys_i);
        pkt <= w;
        avail <= avail + 8'h01;
    endtask
    // walk the chain bits and judge each issued packet in turn
    task automatic expect_word(input fetch_word_type w);
        int s, k, i;
        unit_mask_type m;
        fetch_word_type iw;
        instr_type t;
        logic [3:0] cx;
        s = 0;
        while (s < 8) begin
            m = '0;
            iw = '0;
            cx = '0;
            k = s;
            forever begin
                t = w[32*k +: 32];
                m[t[3:1]] = 1'b1;
                iw[32*t[3:1] +: 32] = t;
                if (t[4]) begin
                    cx[t[3]] = 1'b1;
                    if (t[3:1] == 3'h3) cx[2] = 1'b1;
                    if (t[3:1] == 3'h7) cx[3] = 1'b1;
                end
                if (!t[0] || k == 7) break;
                k++;
            end
            @(negedge clk_sys_i);
            for (i = 0; s == 0 && i < 30 && packet_issued_o !== 1'b1; i++) @(negedge clk_sys_i);
            check(packet_issued_o, 256'(1));
            check(packet_size_o, 256'(k - s + 1));
            check(issue_valid_o, 256'(m));
            check(issue_instr_o, iw);
            check({cross_b_write_o, cross_a_write_o, cross_b_read_o, cross_a_read_o}, 256'(cx));
            if (k < 7) check(fetch_req_o, 256'(0));
            s = k + 1;
        end
    endtask
    ////////////////////////////////////////
    task automatic sc_full_chain;
        offer(word(8'hFF));
        expect_word(word(8'hFF));
    endtask
    task automatic sc_singles;
        offer(word(8'h00));
        offer(word(8'h00));
        expect_word(word(8'h00));
        expect_word(word(8'h00));
    endtask
    task automatic sc_stall;
        int i;
        unit_busy_i <= 8'hFF;
        offer(word(8'h3B));
        @(negedge clk_sys_i);
        for (i = 0; i < 30 && sent !== avail; i++) @(negedge clk_sys_i);
        repeat (4) begin
            @(negedge clk_sys_i);
            check(packet_issued_o, 256'(0));
        end
        unit_busy_i <= 8'h00;
        expect_word(word(8'h3B));
    endtask
    // cross reads on both sides, cross writes from both address units
    task automatic sc_cross;
        offer(xword(8'h33, 8'h9C));
        expect_word(xword(8'h33, 8'h9C));
    endtask
    task automatic conclude;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        srst_i = 1'b1;
        unit_busy_i = 8'h00;
        avail = 8'h00;
        pkt = '0;
        fails = 0;
        checked = 0;
        cycles = 0;
        repeat (10) @(negedge clk_sys_i);
        check(fetch_req_o, 256'(0));
        srst_i = 1'b0;
        @(negedge clk_sys_i);
        check(fetch_req_o, 256'(1));
        sc_full_chain();
        sc_singles();
        sc_stall();
        sc_cross();
        conclude();
    end
endmodule
